// File: include/dpsc_pkg.sv
/*
 * Shared constants of the host-side controller for one port of an
 * 8K x 16 two-port static memory: register map, field positions,
 * reset values, pin timing counts and the sequencer states.
 * Assumes a 20 MHz system clock and a 3-bit Avalon-MM word address.
 */
package dpsc_pkg;

  // ****************************************************************
  // memory geometry
  // ****************************************************************
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 16;
  localparam int LANE_W      = 8;
  localparam int FLAG_ADDR_W = 3;

  // ****************************************************************
  // register map (avalon word addresses)
  // ****************************************************************
  localparam int          AVS_ADDR_W = 3;
  localparam int          AVS_DATA_W = 32;
  localparam logic [2:0]  CTRL_OFS   = 3'h0;
  localparam logic [2:0]  ADDR_OFS   = 3'h1;
  localparam logic [2:0]  WDATA_OFS  = 3'h2;
  localparam logic [2:0]  RDATA_OFS  = 3'h3;
  localparam logic [2:0]  STAT_OFS   = 3'h4;
  localparam logic [2:0]  MASK_OFS   = 3'h5;

  // control register fields
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int CTRL_UPPER_BIT = 2;
  localparam int CTRL_LOWER_BIT = 3;
  localparam int CTRL_FLAG_BIT  = 4;
  localparam int CTRL_MS_BIT    = 5;

  // status and mask register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_DEVINT_BIT = 2;
  localparam int STAT_BUSY_BIT   = 3;
  localparam int STAT_W          = 4;

  // reset values
  localparam logic [STAT_W-1:0] MASK_RST  = 4'h0;
  localparam logic              MS_RST    = 1'b1;
  localparam logic [15:0]       DATA_RST  = 16'h0000;
  localparam logic [12:0]       ADDR_RST  = 13'h0000;

  // ****************************************************************
  // pin timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_SETUP_NS    = 20;
  localparam int T_ACCESS_NS   = 70;
  localparam int T_WPULSE_NS   = 70;
  localparam int SYNC_STAGES   = 2;
  localparam int CNT_W         = 8;

  // least time to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC  = ns_to_cyc(T_SETUP_NS);
  localparam int ACCESS_CYC = ns_to_cyc(T_ACCESS_NS);
  localparam int WPULSE_CYC = ns_to_cyc(T_WPULSE_NS);

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } dpsc_state_t;

endpackage

// File: rtl/dpsc_sync.sv
/*
 * Two-flop synchroniser for a bundle of independent levels.
 * Assumes each bit is a slow level; multi-bit words must be held
 * stable by the far side while they are sampled.
 */
`timescale 1ns/1ps
module dpsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  always_comb begin
    meta_next   = async_in;
    stable_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg   <= RST_VAL;
      stable_reg <= RST_VAL;
    end else begin
      meta_reg   <= meta_next;
      stable_reg <= stable_next;
    end
  end

  assign sync_out = stable_reg;

endmodule

// File: rtl/dpsc_ctrl.sv
/*
 * Host controller for one port of an 8K x 16 two-port static memory.
 * Software orders single word, byte, or semaphore-flag accesses over
 * an Avalon-MM slave; the controller sequences the port pins.
 * Assumes the data, busy and interrupt pins come from outside the
 * clock domain and that the other port is driven by its own host.
 */
`timescale 1ns/1ps
module dpsc_ctrl
  import dpsc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // avalon-mm slave
  input  wire logic [AVS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [AVS_DATA_W-1:0] avs_writedata,
  output logic      [AVS_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  // interrupt
  output logic                       irq,
  // memory port controls
  output logic                       chip_en_n,
  output logic                       rw_n,
  output logic                       out_en_n,
  output logic                       upper_lane_sel_n,
  output logic                       lower_lane_sel_n,
  output logic                       flag_space_sel_n,
  output logic      [ADDR_W-1:0]     left_addr,
  output logic                       ms_sel,
  // memory port data
  input  wire logic [DATA_W-1:0]     left_dq_in,
  output logic      [DATA_W-1:0]     left_dq_out,
  output logic                       left_dq_oe,
  // memory port flags
  input  wire logic                  busy_n,
  input  wire logic                  int_flag_n
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [DATA_W-1:0] dq_sync;
  logic              busy_n_sync;
  logic              int_n_sync;

  dpsc_sync #(
    .WIDTH   (DATA_W),
    .RST_VAL ('0)
  ) u_sync_dq (
    .clk      (clk),
    .reset    (reset),
    .async_in (left_dq_in),
    .sync_out (dq_sync)
  );

  dpsc_sync #(
    .WIDTH   (2),
    .RST_VAL (2'h3)
  ) u_sync_flags (
    .clk      (clk),
    .reset    (reset),
    .async_in ({busy_n, int_flag_n}),
    .sync_out ({busy_n_sync, int_n_sync})
  );

  // ****************************************************************
  // state
  // ****************************************************************
  dpsc_state_t       state_reg,   state_next;
  logic [CNT_W-1:0]  cnt_reg,     cnt_next;
  logic              read_reg,    read_next;
  logic              upper_reg,   upper_next;
  logic              lower_reg,   lower_next;
  logic              flag_reg,    flag_next;
  logic              ms_reg,      ms_next;
  logic [ADDR_W-1:0] addr_reg,    addr_next;
  logic [DATA_W-1:0] wdata_reg,   wdata_next;
  logic [DATA_W-1:0] rdata_reg,   rdata_next;
  logic [STAT_W-1:0] sticky_reg,  sticky_next;
  logic [STAT_W-1:0] mask_reg,    mask_next;
  logic              int_prev_reg, int_prev_next;
  logic              irq_reg,     irq_next;
  logic              wait_reg,    wait_next;
  logic [31:0]       rd_reg,      rd_next;
  logic              ce_reg,      ce_next;
  logic              rw_reg,      rw_next;
  logic              oe_reg,      oe_next;
  logic              ub_reg,      ub_next;
  logic              lb_reg,      lb_next;
  logic              sem_reg,     sem_next;
  logic [ADDR_W-1:0] pa_reg,      pa_next;
  logic [DATA_W-1:0] dq_reg,      dq_next;
  logic              dqoe_reg,    dqoe_next;

  logic              acc_wr;
  logic              acc_rd;
  logic              idle;
  logic              go;
  logic [STAT_W-1:0] events;
  logic              dev_fall;

  // ****************************************************************
  // bus slave: one wait cycle, then the answer
  // ****************************************************************
  always_comb begin
    acc_wr    = avs_write & ~wait_reg;
    acc_rd    = avs_read & ~wait_reg;
    idle      = (state_reg == ST_IDLE);
    go        = acc_wr && avs_address == CTRL_OFS
                && avs_writedata[CTRL_GO_BIT] && idle;
    wait_next = ~((avs_read | avs_write) & wait_reg);
    rd_next   = rd_reg;
    if ((avs_read | avs_write) & wait_reg) begin
      case (avs_address)
        CTRL_OFS:  rd_next = {26'h0, ms_reg, flag_reg, lower_reg,
                              upper_reg, read_reg, ~idle};
        ADDR_OFS:  rd_next = {19'h0, addr_reg};
        WDATA_OFS: rd_next = {16'h0, wdata_reg};
        RDATA_OFS: rd_next = {16'h0, rdata_reg};
        STAT_OFS:  rd_next = {28'h0, sticky_reg[3:1], ~idle};
        MASK_OFS:  rd_next = {28'h0, mask_reg};
        default:   rd_next = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // software settings
  // ****************************************************************
  always_comb begin
    read_next  = read_reg;
    upper_next = upper_reg;
    lower_next = lower_reg;
    flag_next  = flag_reg;
    ms_next    = ms_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    mask_next  = mask_reg;
    if (acc_wr && idle) begin
      case (avs_address)
        CTRL_OFS: begin
          read_next  = avs_writedata[CTRL_READ_BIT];
          upper_next = avs_writedata[CTRL_UPPER_BIT];
          lower_next = avs_writedata[CTRL_LOWER_BIT];
          flag_next  = avs_writedata[CTRL_FLAG_BIT];
          ms_next    = avs_writedata[CTRL_MS_BIT];
        end
        ADDR_OFS:  addr_next  = avs_writedata[ADDR_W-1:0];
        WDATA_OFS: wdata_next = avs_writedata[DATA_W-1:0];
        default:   ;
      endcase
    end
    if (acc_wr && avs_address == MASK_OFS) begin
      mask_next = avs_writedata[STAT_W-1:0];
    end
  end

  // ****************************************************************
  // pin sequencer
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rdata_next = rdata_reg;
    ce_next    = ce_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    ub_next    = ub_reg;
    lb_next    = lb_reg;
    sem_next   = sem_reg;
    pa_next    = pa_reg;
    dq_next    = dq_reg;
    dqoe_next  = dqoe_reg;
    events     = '0;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          // settings written in the same cycle take effect here
          pa_next   = addr_reg;
          dq_next   = wdata_reg;
          rw_next   = 1'b1;
          oe_next   = ~avs_writedata[CTRL_READ_BIT];
          dqoe_next = 1'b0;
          if (avs_writedata[CTRL_FLAG_BIT]) begin
            // flag space: enable and lanes stay high
            sem_next = 1'b0;
            ce_next  = 1'b1;
            ub_next  = 1'b1;
            lb_next  = 1'b1;
          end else begin
            sem_next = 1'b1;
            ce_next  = 1'b0;
            ub_next  = ~avs_writedata[CTRL_UPPER_BIT];
            lb_next  = ~avs_writedata[CTRL_LOWER_BIT];
          end
          cnt_next   = CNT_W'(SETUP_CYC);
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_reg > CNT_W'(1)) begin
          cnt_next = cnt_reg - CNT_W'(1);
        end else if (read_reg) begin
          // data must also cross the synchroniser
          cnt_next   = CNT_W'(ACCESS_CYC + SYNC_STAGES);
          state_next = ST_STROBE;
        end else begin
          rw_next    = 1'b0;
          dqoe_next  = 1'b1;
          cnt_next   = CNT_W'(WPULSE_CYC);
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!busy_n_sync) begin
          // arbitration lost: hold the access until released
          events[STAT_BUSY_BIT] = 1'b1;
          if (cnt_reg < CNT_W'(2)) begin
            cnt_next = CNT_W'(2);
          end
        end else if (cnt_reg > CNT_W'(1)) begin
          cnt_next = cnt_reg - CNT_W'(1);
        end else begin
          if (read_reg) begin
            rdata_next = dq_sync;
          end
          rw_next    = 1'b1;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // data is held one cycle past the rising write strobe
        ce_next   = 1'b1;
        sem_next  = 1'b1;
        oe_next   = 1'b1;
        ub_next   = 1'b1;
        lb_next   = 1'b1;
        dqoe_next = 1'b0;
        events[STAT_DONE_BIT] = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // sticky status and interrupt
  // ****************************************************************
  always_comb begin
    int_prev_next = int_n_sync;
    dev_fall      = int_prev_reg & ~int_n_sync;
    sticky_next   = sticky_reg;
    if (acc_rd && avs_address == STAT_OFS) begin
      // clear only the bits that the answered read reported
      sticky_next = sticky_reg & ~{rd_reg[STAT_W-1:1], 1'b0};
    end
    // a new event wins over the clearing read
    sticky_next = sticky_next | events;
    sticky_next[STAT_DEVINT_BIT] = sticky_next[STAT_DEVINT_BIT] | dev_fall;
    irq_next    = |(sticky_next & mask_next);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= '0;
      read_reg     <= 1'b0;
      upper_reg    <= 1'b0;
      lower_reg    <= 1'b0;
      flag_reg     <= 1'b0;
      ms_reg       <= MS_RST;
      addr_reg     <= ADDR_RST;
      wdata_reg    <= DATA_RST;
      rdata_reg    <= DATA_RST;
      sticky_reg   <= '0;
      mask_reg     <= MASK_RST;
      int_prev_reg <= 1'b1;
      irq_reg      <= 1'b0;
      wait_reg     <= 1'b1;
      rd_reg       <= 32'h0000_0000;
      ce_reg       <= 1'b1;
      rw_reg       <= 1'b1;
      oe_reg       <= 1'b1;
      ub_reg       <= 1'b1;
      lb_reg       <= 1'b1;
      sem_reg      <= 1'b1;
      pa_reg       <= ADDR_RST;
      dq_reg       <= DATA_RST;
      dqoe_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      read_reg     <= read_next;
      upper_reg    <= upper_next;
      lower_reg    <= lower_next;
      flag_reg     <= flag_next;
      ms_reg       <= ms_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
      sticky_reg   <= sticky_next;
      mask_reg     <= mask_next;
      int_prev_reg <= int_prev_next;
      irq_reg      <= irq_next;
      wait_reg     <= wait_next;
      rd_reg       <= rd_next;
      ce_reg       <= ce_next;
      rw_reg       <= rw_next;
      oe_reg       <= oe_next;
      ub_reg       <= ub_next;
      lb_reg       <= lb_next;
      sem_reg      <= sem_next;
      pa_reg       <= pa_next;
      dq_reg       <= dq_next;
      dqoe_reg     <= dqoe_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata     = rd_reg;
  assign avs_waitrequest  = wait_reg;
  assign irq              = irq_reg;
  assign chip_en_n        = ce_reg;
  assign rw_n             = rw_reg;
  assign out_en_n         = oe_reg;
  assign upper_lane_sel_n = ub_reg;
  assign lower_lane_sel_n = lb_reg;
  assign flag_space_sel_n = sem_reg;
  assign left_addr        = pa_reg;
  assign ms_sel           = ms_reg;
  assign left_dq_out      = dq_reg;
  assign left_dq_oe       = dqoe_reg;

endmodule

// File: test/dpsc_ctrl_properties.sv
/*
 * Pin and bus handshake checker for dpsc_ctrl.
 * Assumes it is bound to dpsc_ctrl and that all of it runs on clk.
 */
`timescale 1ns/1ps
module dpsc_ctrl_properties
  import dpsc_pkg::*;
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // avalon-mm
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  // memory port
  input wire logic                  chip_en_n,
  input wire logic                  rw_n,
  input wire logic                  out_en_n,
  input wire logic                  upper_lane_sel_n,
  input wire logic                  lower_lane_sel_n,
  input wire logic                  flag_space_sel_n,
  input wire logic [ADDR_W-1:0]     left_addr,
  input wire logic                  ms_sel,
  input wire logic [DATA_W-1:0]     left_dq_out,
  input wire logic                  left_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_float: assert property (
    chip_en_n && flag_space_sel_n |-> !left_dq_oe && out_en_n && rw_n)
    else $error("deselected port still active");
  a_write_sel: assert property (
    !rw_n && flag_space_sel_n |-> !chip_en_n && left_dq_oe)
    else $error("write strobe without enable or data");
  a_strobe_min: assert property (
    $fell(rw_n) |-> !rw_n [*2])
    else $error("write strobe too short");
  a_strobe_end: assert property (
    $fell(rw_n) |-> ##[2:40] rw_n)
    else $error("write strobe never ends");
  a_strobe_hold: assert property (
    $rose(rw_n) |-> left_dq_oe && $stable(left_dq_out) && $stable(left_addr))
    else $error("data or address moved at strobe end");
  a_read_quiet: assert property (
    !out_en_n |-> rw_n && !left_dq_oe)
    else $error("controller drives data during read");
  a_read_window: assert property (
    $fell(out_en_n) |-> !out_en_n [*4])
    else $error("read window too short");
  a_flag_only: assert property (
    !flag_space_sel_n |-> chip_en_n && upper_lane_sel_n && lower_lane_sel_n)
    else $error("flag access overlaps array access");
  a_ms_change: assert property (
    $changed(ms_sel) |->
      $past(avs_write && !avs_waitrequest && avs_address == CTRL_OFS))
    else $error("ms_sel changed without control write");

  c_write: cover property ($fell(rw_n) && flag_space_sel_n);
  c_read: cover property ($fell(out_en_n) && flag_space_sel_n);
  c_flag: cover property (!flag_space_sel_n && !rw_n);
endmodule

bind dpsc_ctrl dpsc_ctrl_properties dpsc_ctrl_properties_i (.clk, .reset,
  .avs_address, .avs_read, .avs_write, .avs_waitrequest, .chip_en_n, .rw_n,
  .out_en_n, .upper_lane_sel_n, .lower_lane_sel_n, .flag_space_sel_n,
  .left_addr, .ms_sel, .left_dq_out, .left_dq_oe);

// File: test/dpsc_mem_model.sv
/*
 * Behavioural model of one port of the two-port static memory.
 * Assumes the bench resolves the data wire from both drivers.
 */
`timescale 1ns/1ps
module dpsc_mem_model
  import dpsc_pkg::*;
(
  // paces the floating-line pattern only
  input  wire logic              clk,
  // port controls
  input  wire logic              chip_en_n,
  input  wire logic              rw_n,
  input  wire logic              out_en_n,
  input  wire logic              upper_lane_sel_n,
  input  wire logic              lower_lane_sel_n,
  input  wire logic              flag_space_sel_n,
  input  wire logic [ADDR_W-1:0] left_addr,
  // data
  input  wire logic [DATA_W-1:0] dq_wire,
  output logic      [DATA_W-1:0] dq_drv,
  // flags
  input  wire logic              busy_req,
  input  wire logic              int_req,
  output logic                   busy_n,
  output logic                   int_flag_n
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0]        flags = 8'h00;
  logic              tick = 1'b0;
  logic [DATA_W-1:0] word, junk;
  logic              up_en, lo_en, sem_rd;

  always @(posedge clk) tick <= ~tick;

  // writes land as the strobe rises, on levels only
  always @(posedge rw_n) begin
    if (!chip_en_n && flag_space_sel_n) begin
      if (!upper_lane_sel_n) mem[left_addr][15:8] = dq_wire[15:8];
      if (!lower_lane_sel_n) mem[left_addr][7:0] = dq_wire[7:0];
    end else if (!flag_space_sel_n && chip_en_n)
      flags[left_addr[2:0]] = dq_wire[0];
  end

  // released lanes show a changing pattern
  always_comb begin
    junk   = tick ? 16'hA5C3 : 16'h5A3C;
    sem_rd = !flag_space_sel_n && chip_en_n;
    word   = sem_rd ? {DATA_W{flags[left_addr[2:0]]}} : mem[left_addr];
    up_en  = rw_n && !out_en_n && (sem_rd ||
             (!chip_en_n && flag_space_sel_n && !upper_lane_sel_n));
    lo_en  = rw_n && !out_en_n && (sem_rd ||
             (!chip_en_n && flag_space_sel_n && !lower_lane_sel_n));
    dq_drv = {up_en ? word[15:8] : junk[15:8], lo_en ? word[7:0] : junk[7:0]};
  end

  assign busy_n     = !busy_req;
  assign int_flag_n = !int_req;
endmodule

// File: test/dpsc_ctrl_tb.sv
/*
 * Self-checking bench for dpsc_ctrl with a memory port model.
 * Assumes the register map and timing of dpsc_pkg.
 */
`timescale 1ns/1ps
module dpsc_ctrl_tb
  import dpsc_pkg::*;
;
  logic                  clk, reset, avs_read, avs_write, busy_req, int_req;
  logic [AVS_ADDR_W-1:0] avs_address;
  logic [AVS_DATA_W-1:0] avs_writedata, avs_readdata, bq, e, m;
  logic                  avs_waitrequest, irq, chip_en_n, rw_n, out_en_n;
  logic                  upper_lane_sel_n, lower_lane_sel_n, flag_space_sel_n;
  logic                  ms_sel, left_dq_oe, busy_n, int_flag_n;
  logic [ADDR_W-1:0]     left_addr;
  logic [DATA_W-1:0]     left_dq_out, dq_drv, dq_wire, d;
  logic [31:0]           exp_q[$], msk_q[$];
  logic [DATA_W-1:0]     sh [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0]     adr [4];
  logic [3:0]            rc [4] = '{4'h7, 4'h7, 4'h3, 4'h5};
  logic [31:0]           rm [4] = '{32'hFFFF, 32'hFFFF, 32'hFF00, 32'hFF};
  int                    error_cnt, n_tests, seed, k;

  assign dq_wire = left_dq_oe ? left_dq_out : dq_drv;

  dpsc_ctrl dpsc_ctrl_i (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .chip_en_n, .rw_n,
    .out_en_n, .upper_lane_sel_n, .lower_lane_sel_n, .flag_space_sel_n,
    .left_addr, .ms_sel, .left_dq_in(dq_wire), .left_dq_out, .left_dq_oe,
    .busy_n, .int_flag_n);
  dpsc_mem_model dpsc_mem_model_i (.clk, .chip_en_n, .rw_n, .out_en_n,
    .upper_lane_sel_n, .lower_lane_sel_n, .flag_space_sel_n, .left_addr,
    .dq_wire, .dq_drv, .busy_req, .int_req, .busy_n, .int_flag_n);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp(input string nm, input logic [31:0] ev, gv);
    n_tests++;
    if (gv !== ev) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] v);
    @(posedge clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= v;
    // waitrequest is looked at between edges, where it is settled
    do @(negedge clk); while (avs_waitrequest !== 1'b0);
    bq = avs_readdata;
    @(posedge clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask

  task automatic rd(input logic [2:0] a, input logic [31:0] ev, mv);
    exp_q.push_back(ev & mv);
    msk_q.push_back(mv);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic go(input logic [3:0] c, input logic [12:0] a,
                    input logic [15:0] v);
    wr(ADDR_OFS, {19'h0, a});
    wr(WDATA_OFS, {16'h0, v});
    wr(CTRL_OFS, {27'h1, c, 1'b1});
  endtask

  task automatic fin;
    bq = 32'h0;
    k  = 0;
    while (bq[STAT_DONE_BIT] !== 1'b1 && k < 40) begin
      rd(STAT_OFS, 32'h0, 32'h0);
      k++;
    end
    cmp("done", 32'h1, {31'h0, bq[STAT_DONE_BIT]});
  endtask

  task automatic acc(input logic [3:0] c, input logic [12:0] a,
                     input logic [15:0] v);
    go(c, a, v);
    fin();
  endtask

  always @(negedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) cmp("readdata", e, avs_readdata & m);
    end
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    seed = 50;
    error_cnt = 0;
    n_tests = 0;
    reset = 1'b1;
    {avs_read, avs_write, busy_req, int_req} = 4'h0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(MASK_OFS, 32'h0, 32'hFFFFFFFF);
    wr(3'h7, $random(seed));
    rd(3'h7, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      adr[i] = (i == 3) ? 13'h1FFF : 13'(i * 2048 + {$random(seed)} % 2048);
      sh[adr[i]] = 16'($random(seed));
      acc(4'h6, adr[i], sh[adr[i]]);
    end
    d = 16'($random(seed));
    acc(4'h2, adr[0], d);
    sh[adr[0]][15:8] = d[15:8];
    acc(4'h4, adr[1], d);
    sh[adr[1]][7:0] = d[7:0];
    for (int i = 0; i < 4; i++) begin
      acc(rc[i], adr[i], 16'h0);
      rd(RDATA_OFS, {16'h0, sh[adr[i]]}, rm[i]);
    end
    for (int j = 0; j < 2; j++) acc(4'h8, 13'(2 + j), 16'(j));
    for (int j = 0; j < 2; j++) begin
      acc(4'h9, 13'(2 + j), 16'h0);
      rd(RDATA_OFS, 32'(j), 32'h1);
    end
    go(4'h6, adr[2], 16'h5A5A);
    wr(WDATA_OFS, 32'hA5A5);
    fin();
    rd(WDATA_OFS, 32'h5A5A, 32'hFFFF);
    acc(4'h7, adr[2], 16'h0);
    rd(RDATA_OFS, 32'h5A5A, 32'hFFFF);
    wr(MASK_OFS, 32'h2);
    go(4'h6, adr[3], 16'hC3C3);
    k = 0;
    while (irq !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    cmp("irq", 32'h1, {31'h0, irq});
    rd(STAT_OFS, 32'h2, 32'h2);
    repeat (2) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(MASK_OFS, 32'h0);
    int_req <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(MASK_OFS, 32'h4);
    repeat (3) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    int_req <= 1'b0;
    rd(STAT_OFS, 32'h4, 32'h4);
    wr(MASK_OFS, 32'h0);
    busy_req <= 1'b1;
    go(4'h6, adr[1], 16'h0F0F);
    repeat (6) @(posedge clk);
    cmp("rw_n", 32'h0, {31'h0, rw_n});
    busy_req <= 1'b0;
    repeat (12) @(posedge clk);
    rd(STAT_OFS, 32'hA, 32'hA);
    acc(4'h7, adr[1], 16'h0);
    rd(RDATA_OFS, 32'h0F0F, 32'hFFFF);
    for (int j = 0; j < 2; j++) begin
      wr(CTRL_OFS, 32'(j) << CTRL_MS_BIT);
      repeat (2) @(posedge clk);
      cmp("ms_sel", 32'(j), {31'h0, ms_sel});
    end
    end_sim();
  end

  initial begin
    #(50 * 20000);
    error_cnt++;
    end_sim();
  end
endmodule
